// File: uart_reset_pkg.sv
// Package: register offsets, reset values and field positions of the dual channel
package uart_reset_pkg;

  localparam int          NUM_CHANNELS = 2;
  localparam int          ADDR_W       = 6;
  localparam int          DATA_W       = 8;

  // Register index within a channel; bit 5 of the address picks the channel
  localparam logic [4:0] OFS_RX_TX_HOLD   = 5'h00;
  localparam logic [4:0] OFS_INT_ENABLE   = 5'h01;
  localparam logic [4:0] OFS_INT_FIFO     = 5'h02;
  localparam logic [4:0] OFS_LINE_CTRL    = 5'h03;
  localparam logic [4:0] OFS_MODEM_CTRL   = 5'h04;
  localparam logic [4:0] OFS_LINE_STAT    = 5'h05;
  localparam logic [4:0] OFS_MODEM_STAT   = 5'h06;
  localparam logic [4:0] OFS_SCRATCH      = 5'h07;
  localparam logic [4:0] OFS_DIV_LOW      = 5'h08;
  localparam logic [4:0] OFS_DIV_HIGH     = 5'h09;
  localparam logic [4:0] OFS_DIV_FRAC     = 5'h0A;
  localparam logic [4:0] OFS_FEAT_CTRL    = 5'h0B;
  localparam logic [4:0] OFS_ENH_FEAT     = 5'h0C;
  localparam logic [4:0] OFS_TX_LEVEL     = 5'h0D;
  localparam logic [4:0] OFS_TX_TRIGGER   = 5'h0E;
  localparam logic [4:0] OFS_RX_LEVEL     = 5'h0F;
  localparam logic [4:0] OFS_RX_TRIGGER   = 5'h10;
  localparam logic [4:0] OFS_FLOW_STAT    = 5'h11;
  localparam logic [4:0] OFS_RESUME_1     = 5'h12;
  localparam logic [4:0] OFS_RESUME_2     = 5'h13;
  localparam logic [4:0] OFS_PAUSE_1      = 5'h14;
  localparam logic [4:0] OFS_PAUSE_2      = 5'h15;
  localparam logic [4:0] OFS_CHAN_CTRL    = 5'h16;

  // Reset values
  localparam logic [7:0] RST_ZERO         = 8'h00;
  localparam logic [7:0] RST_DIV_LOW      = 8'h01;
  localparam logic [7:0] RST_INT_STATUS   = 8'h01;
  localparam logic [7:0] RST_LINE_STATUS  = 8'h60;
  localparam logic [7:0] RST_SCRATCH      = 8'hFF;

  // Field positions
  localparam int         ENH_SWFLOW_LSB   = 0;
  localparam int         MODEM_CTRL_DTR_BIT  = 0;
  localparam int         MODEM_CTRL_RTS_BIT  = 1;
  localparam int         MODEM_CTRL_LOOP_BIT = 4;
  localparam int         FEAT_CTRL_IR_BIT    = 4;
  localparam int         CHCTL_TXFLAG_BIT = 0;

endpackage : uart_reset_pkg

// File: uart_flow_status.sv
// Flow-control character status flags with clear-on-read and disable clear
`timescale 1ns/1ns
module uart_flow_status (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Control
  input  wire logic       swFlowEnable,
  input  wire logic       readClear,
  input  wire logic [3:0] flagSet,
  // Status
  output logic      [3:0] flags
);
  import uart_reset_pkg::*;

  typedef struct packed {
    logic [3:0] flags;
  } state_s;

  state_s stateReg;
  state_s stateNext;

  always_comb begin
    stateNext = stateReg;
    if (!swFlowEnable) begin
      stateNext.flags = 4'h0;
    end else begin
      // A flag raised in the reading cycle survives the clear
      stateNext.flags = (readClear ? 4'h0 : stateReg.flags) | flagSet;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stateReg.flags <= RST_ZERO[3:0];
    end else begin
      stateReg <= stateNext;
    end
  end

  assign flags = stateReg.flags;

  property p_flow_clear;
    @(posedge core_clk) disable iff (rst)
      !swFlowEnable |=> (flags == 4'h0);
  endproperty
  a_flow_clear: assert property (p_flow_clear) else $error("flow status not cleared");

endmodule // uart_flow_status

// File: uart_channel_regs.sv
// One channel's register set, pin levels and reset values
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ns
module uart_channel_regs (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [4:0] regIdx,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStb,
  input  wire logic       rdStb,
  output logic      [7:0] rdData,
  // Modem inputs, active low: cts dsr ri cd in bits 0..3
  input  wire logic [3:0] modemInN,
  input  wire logic       rxIn,
  input  wire logic       irRxIn,
  // Line pins
  output logic            txOut,
  output logic            infraredTxOut,
  output logic            rtsN,
  output logic            dtrN,
  // Flow character events from the line engine
  input  wire logic [3:0] flowEvent
);
  import uart_reset_pkg::*;

  typedef struct packed {
    logic [7:0] divLow;
    logic [7:0] divHigh;
    logic [7:0] divFrac;
    logic [7:0] rxHold;
    logic [7:0] txHold;
    logic [7:0] intEnable;
    logic [7:0] fifoCtrl;
    logic [7:0] intStatus;
    logic [7:0] lineCtrl;
    logic [7:0] modemCtrl;
    logic [7:0] lineStatus;
    logic [3:0] modemDelta;
    logic [3:0] modemPrev;
    logic       modemPrimed;
    logic [7:0] scratch;
    logic [7:0] featCtrl;
    logic [7:0] enhFeat;
    logic [7:0] txLevel;
    logic [7:0] txTrigger;
    logic [7:0] rxLevel;
    logic [7:0] rxTrigger;
    logic [7:0] resume1;
    logic [7:0] resume2;
    logic [7:0] pause1;
    logic [7:0] pause2;
    logic [7:0] chanCtrl;
    logic [7:0] rdData;
  } state_s;

  state_s     stateReg;
  state_s     stateNext;
  logic [3:0] flowFlags;
  logic [3:0] modemLevel;
  logic [7:0] modemStatus;
  logic [3:0] modemChange;
  logic       swFlowOn;

  assign modemLevel  = ~modemInN;
  // Upper nibble follows the pins live; only the delta nibble is stored
  assign modemStatus = {modemLevel, stateReg.modemDelta};
  // Previous levels are unknown until the first edge after reset, so no change yet
  assign modemChange = stateReg.modemPrimed ? (modemLevel ^ stateReg.modemPrev) : 4'h0;
  assign swFlowOn    = stateReg.enhFeat[ENH_SWFLOW_LSB +: 4] != 4'h0;

  uart_flow_status flowStatus (
    .core_clk     (core_clk),
    .rst          (rst),
    .swFlowEnable (swFlowOn),
    .readClear    (rdStb && regIdx == OFS_FLOW_STAT),
    .flagSet      (flowEvent),
    .flags        (flowFlags)
  );

  always_comb begin
    stateNext            = stateReg;
    stateNext.modemPrev  = modemLevel;
    stateNext.modemPrimed = 1'b1;
    stateNext.modemDelta = stateReg.modemDelta | modemChange;
    stateNext.rdData     = 8'h00;
    if (rdStb) begin
      unique case (regIdx)
        OFS_RX_TX_HOLD: stateNext.rdData = stateReg.rxHold;
        OFS_INT_ENABLE: stateNext.rdData = stateReg.intEnable;
        OFS_INT_FIFO:   stateNext.rdData = stateReg.intStatus;
        OFS_LINE_CTRL:  stateNext.rdData = stateReg.lineCtrl;
        OFS_MODEM_CTRL: stateNext.rdData = stateReg.modemCtrl;
        OFS_LINE_STAT:  stateNext.rdData = stateReg.lineStatus;
        OFS_MODEM_STAT: begin
          stateNext.rdData     = modemStatus;
          stateNext.modemDelta = modemChange;
        end
        OFS_SCRATCH:    stateNext.rdData = stateReg.scratch;
        OFS_DIV_LOW:    stateNext.rdData = stateReg.divLow;
        OFS_DIV_HIGH:   stateNext.rdData = stateReg.divHigh;
        OFS_DIV_FRAC:   stateNext.rdData = stateReg.divFrac;
        OFS_FEAT_CTRL:  stateNext.rdData = stateReg.featCtrl;
        OFS_ENH_FEAT:   stateNext.rdData = stateReg.enhFeat;
        OFS_TX_LEVEL:   stateNext.rdData = stateReg.txLevel;
        OFS_RX_LEVEL:   stateNext.rdData = stateReg.rxLevel;
        OFS_FLOW_STAT:  stateNext.rdData = {4'h0, flowFlags};
        OFS_CHAN_CTRL:  stateNext.rdData = stateReg.chanCtrl;
        default:        stateNext.rdData = 8'h00;
      endcase
    end
    if (wrStb) begin
      unique case (regIdx)
        OFS_RX_TX_HOLD: begin
          stateNext.txHold     = wrData;
          // Transmit engine is outside this block: a write leaves holding full
          stateNext.lineStatus = stateReg.lineStatus & 8'h9F;
        end
        OFS_INT_ENABLE: stateNext.intEnable = wrData;
        OFS_INT_FIFO:   stateNext.fifoCtrl  = wrData;
        OFS_LINE_CTRL:  stateNext.lineCtrl  = wrData;
        OFS_MODEM_CTRL: stateNext.modemCtrl = wrData;
        OFS_SCRATCH:    stateNext.scratch   = wrData;
        OFS_DIV_LOW:    stateNext.divLow    = wrData;
        OFS_DIV_HIGH:   stateNext.divHigh   = wrData;
        OFS_DIV_FRAC:   stateNext.divFrac   = wrData;
        OFS_FEAT_CTRL:  stateNext.featCtrl  = wrData;
        OFS_ENH_FEAT:   stateNext.enhFeat   = wrData;
        OFS_TX_TRIGGER: stateNext.txTrigger = wrData;
        OFS_RX_TRIGGER: stateNext.rxTrigger = wrData;
        OFS_RESUME_1:   stateNext.resume1   = wrData;
        OFS_RESUME_2:   stateNext.resume2   = wrData;
        OFS_PAUSE_1:    stateNext.pause1    = wrData;
        OFS_PAUSE_2:    stateNext.pause2    = wrData;
        OFS_CHAN_CTRL:  stateNext.chanCtrl  = wrData;
        default:        stateNext.rdData    = stateNext.rdData;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stateReg            <= '0;
      stateReg.divLow     <= RST_DIV_LOW;
      stateReg.divHigh    <= RST_ZERO;
      stateReg.divFrac    <= RST_ZERO;
      stateReg.intStatus  <= RST_INT_STATUS;
      stateReg.lineStatus <= RST_LINE_STATUS;
      stateReg.modemDelta <= RST_ZERO[3:0];
      stateReg.modemPrimed <= 1'b0;
      stateReg.scratch    <= RST_SCRATCH;
      stateReg.intEnable  <= RST_ZERO;
      stateReg.fifoCtrl   <= RST_ZERO;
      stateReg.lineCtrl   <= RST_ZERO;
      stateReg.modemCtrl  <= RST_ZERO;
      stateReg.featCtrl   <= RST_ZERO;
      stateReg.enhFeat    <= RST_ZERO;
      stateReg.txLevel    <= RST_ZERO;
      stateReg.rxLevel    <= RST_ZERO;
      stateReg.txTrigger  <= RST_ZERO;
      stateReg.rxTrigger  <= RST_ZERO;
      stateReg.resume1    <= RST_ZERO;
      stateReg.resume2    <= RST_ZERO;
      stateReg.pause1     <= RST_ZERO;
      stateReg.pause2     <= RST_ZERO;
      // Holding registers cleared only for lint; content is undefined
    end else begin
      stateReg <= stateNext;
    end
  end

  // Pins: reset forces idle levels combinationally, so they hold while rst is high
  always_comb begin
    if (rst) begin
      txOut         = 1'b1;
      infraredTxOut = 1'b0;
      rtsN          = 1'b1;
      dtrN          = 1'b1;
    end else begin
      // Line engine sits outside; idle mark unless break bit or infrared mode bit set
      txOut         = ~stateReg.lineCtrl[6] & ~stateReg.featCtrl[FEAT_CTRL_IR_BIT];
      infraredTxOut = 1'b0;
      rtsN          = ~stateReg.modemCtrl[MODEM_CTRL_RTS_BIT];
      dtrN          = ~stateReg.modemCtrl[MODEM_CTRL_DTR_BIT];
    end
  end

  assign rdData = stateReg.rdData;

  property p_pins_reset;
    @(posedge core_clk) rst |-> (txOut && !infraredTxOut && rtsN && dtrN);
  endproperty
  a_pins_reset: assert property (p_pins_reset) else $error("pins not idle in reset");

  property p_modem_stat_high;
    @(posedge core_clk) disable iff (rst)
      rdStb && regIdx == OFS_MODEM_STAT |=> rdData[7:4] == $past(modemLevel);
  endproperty
  a_modem_stat_high: assert property (p_modem_stat_high) else $error("modem status high nibble wrong");

  property p_reset_regs;
    @(posedge core_clk) $fell(rst) |-> (stateReg.divLow == 8'h01 && stateReg.divHigh == 8'h00
      && stateReg.intStatus == 8'h01 && stateReg.lineStatus == 8'h60
      && stateReg.scratch == 8'hFF && stateReg.enhFeat == 8'h00);
  endproperty
  a_reset_regs: assert property (p_reset_regs) else $error("reset values wrong");

endmodule // uart_channel_regs

// File: uart_dual_reset_top.sv
// Dual channel register block with documented reset state
// Summary of operation
// - While reset is held both active-low modem control outputs of each channel sit high.
// - Reset loads divisor low with one and clears divisor high and fraction.
// - Reset sets interrupt status to one, meaning nothing pending.
// - Reset sets line status to 0x60, holding and transmitter empty.
// - Reset clears the modem status low nibble; the high nibble shows the inverted modem pin levels.
// - Reset sets the scratchpad of each channel to all ones.
// - Holding registers have no defined reset content.
// - Reset clears interrupt enable, fifo control, line control and modem control.
// - Reset clears feature control and enhanced feature registers.
// - Reset clears the fifo level counters and trigger level registers.
// - Reset clears flow character status and the four pause and resume characters.
// - Flow character status reads zero from the first clock after software flow control is turned off.
`timescale 1ns/1ns
module uart_dual_reset_top (
  // Clock and reset
  input  wire logic                                   core_clk,
  input  wire logic                                   rst,
  // Register port; address bit 5 selects the channel
  input  wire logic [uart_reset_pkg::ADDR_W-1:0]      regAddr,
  input  wire logic [uart_reset_pkg::DATA_W-1:0]      regWrData,
  input  wire logic                                   regWrStb,
  input  wire logic                                   regRdStb,
  output logic      [uart_reset_pkg::DATA_W-1:0]      regRdData,
  // Channel inputs
  input  wire logic [uart_reset_pkg::NUM_CHANNELS-1:0] rxIn,
  input  wire logic [uart_reset_pkg::NUM_CHANNELS-1:0] irRxIn,
  input  wire logic [3:0]                             modemInN [uart_reset_pkg::NUM_CHANNELS],
  input  wire logic [3:0]                             flowEvent [uart_reset_pkg::NUM_CHANNELS],
  // Channel outputs
  output logic      [uart_reset_pkg::NUM_CHANNELS-1:0] txOut,
  output logic      [uart_reset_pkg::NUM_CHANNELS-1:0] infraredTxOut,
  output logic      [uart_reset_pkg::NUM_CHANNELS-1:0] rtsN,
  output logic      [uart_reset_pkg::NUM_CHANNELS-1:0] dtrN,
  // Eeprom pins
  output logic                                        eepromClockPin,
  output logic                                        eepromSelectPin,
  output logic                                        eepromSerialOutPin
);
  import uart_reset_pkg::*;

  typedef struct packed {
    logic rdChan;
  } state_s;

  state_s     stateReg;
  state_s     stateNext;
  logic [7:0] chanRd [NUM_CHANNELS];

  // Both channels share reset and clock, so they leave reset together
  for (genvar ch = 0; ch < NUM_CHANNELS; ch++) begin : gChan
    logic sel;
    assign sel = regAddr[5] == 1'(ch);
    uart_channel_regs chan (
      .core_clk      (core_clk),
      .rst           (rst),
      .regIdx        (regAddr[4:0]),
      .wrData        (regWrData),
      .wrStb         (regWrStb && sel),
      .rdStb         (regRdStb && sel),
      .rdData        (chanRd[ch]),
      .modemInN      (modemInN[ch]),
      .rxIn          (rxIn[ch]),
      .irRxIn        (irRxIn[ch]),
      .txOut         (txOut[ch]),
      .infraredTxOut (infraredTxOut[ch]),
      .rtsN          (rtsN[ch]),
      .dtrN          (dtrN[ch]),
      .flowEvent     (flowEvent[ch])
    );
  end

  always_comb begin
    stateNext        = stateReg;
    if (regRdStb) begin
      stateNext.rdChan = regAddr[5];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

  // Channel latched with the read strobe steers the registered read data
  assign regRdData = chanRd[stateReg.rdChan];

  // Eeprom loader is not modelled here; pins stay at their idle low
  assign eepromClockPin     = 1'b0;
  assign eepromSelectPin    = 1'b0;
  assign eepromSerialOutPin = 1'b0;

  property p_eeprom_low;
    @(posedge core_clk) rst |-> !(eepromClockPin || eepromSelectPin || eepromSerialOutPin);
  endproperty
  a_eeprom_low: assert property (p_eeprom_low) else $error("eeprom pins not low");

  property p_same_reset;
    @(posedge core_clk) $fell(rst) |-> (txOut == '1) && (rtsN == '1) && (dtrN == '1)
      && (infraredTxOut == '0);
  endproperty
  a_same_reset: assert property (p_same_reset) else $error("channels differ after reset");

endmodule // uart_dual_reset_top

// File: line_partner.sv
// Line transceiver model standing on both channels' serial and modem pins
`timescale 1ns/1ns
module line_partner (
  // Clock
  input  wire logic                                    core_clk,
  // Modem levels the far side presents, active low
  input  wire logic [3:0]                              modemSetN [uart_reset_pkg::NUM_CHANNELS],
  // Device outputs
  input  wire logic [uart_reset_pkg::NUM_CHANNELS-1:0] txOut,
  input  wire logic [uart_reset_pkg::NUM_CHANNELS-1:0] rtsN,
  input  wire logic [uart_reset_pkg::NUM_CHANNELS-1:0] dtrN,
  // Device inputs, and the transmit level seen last cycle
  output logic      [uart_reset_pkg::NUM_CHANNELS-1:0] rxIn,
  output logic      [uart_reset_pkg::NUM_CHANNELS-1:0] irRxIn,
  output logic      [3:0]                              modemInN [uart_reset_pkg::NUM_CHANNELS],
  output logic      [uart_reset_pkg::NUM_CHANNELS-1:0] lastTx
);
  import uart_reset_pkg::*;
  // ==========================================================
  // Idle line levels
  // ==========================================================
  // Receive line rests at mark, infrared receiver sees no pulses
  assign rxIn     = '1;
  assign irRxIn   = '0;
  assign modemInN = modemSetN;
  always_ff @(posedge core_clk) begin
    lastTx <= txOut;
  end
endmodule // line_partner

// File: tb.sv
// Self-checking testbench for the dual channel reset state block
`timescale 1ns/1ns
module tb;
  import uart_reset_pkg::*;
  logic                    core_clk = 1'b0;
  logic                    rst      = 1'b1;
  logic [ADDR_W-1:0]       regAddr  = '0;
  logic [DATA_W-1:0]       regWrData = '0;
  logic                    regWrStb = 1'b0;
  logic                    regRdStb = 1'b0;
  logic [DATA_W-1:0]       regRdData;
  logic [NUM_CHANNELS-1:0] rxIn, irRxIn, txOut, infraredTxOut, rtsN, dtrN, lastTx;
  logic [3:0]              modemInN [NUM_CHANNELS];
  logic [3:0]              modemSetN [NUM_CHANNELS] = '{4'hF, 4'hF};
  logic [3:0]              flowEvent [NUM_CHANNELS] = '{4'h0, 4'h0};
  logic                    eepromClockPin, eepromSelectPin, eepromSerialOutPin;
  int                      n_errors = 0;
  int                      checked  = 0;
  // Registers read after reset, with their expected values; trigger, pause and resume are not readable and read zero
  localparam logic [4:0] RIDX [20] = '{OFS_INT_ENABLE, OFS_INT_FIFO, OFS_LINE_CTRL,
    OFS_MODEM_CTRL, OFS_LINE_STAT, OFS_SCRATCH, OFS_DIV_LOW, OFS_DIV_HIGH, OFS_DIV_FRAC,
    OFS_FEAT_CTRL, OFS_ENH_FEAT, OFS_TX_LEVEL, OFS_RX_LEVEL, OFS_FLOW_STAT, OFS_TX_TRIGGER,
    OFS_RX_TRIGGER, OFS_RESUME_1, OFS_RESUME_2, OFS_PAUSE_1, OFS_PAUSE_2};
  localparam logic [7:0] REXP [20] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'hFF, 8'h01,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00};
  // Writes that move ten of the writable registers and the pins off their reset values
  localparam logic [4:0] WIDX [10] = '{OFS_DIV_LOW, OFS_DIV_HIGH, OFS_DIV_FRAC,
    OFS_INT_ENABLE, OFS_LINE_CTRL, OFS_MODEM_CTRL, OFS_SCRATCH, OFS_RX_TX_HOLD,
    OFS_FEAT_CTRL, OFS_ENH_FEAT};
  localparam logic [7:0] WVAL [10] = '{8'h5A, 8'h12, 8'h03, 8'h0F, 8'h43, 8'h03, 8'h3C,
    8'h55, 8'h20, 8'h0A};

  always #2 core_clk = ~core_clk;

  uart_dual_reset_top u_dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .rxIn(rxIn), .irRxIn(irRxIn), .modemInN(modemInN), .flowEvent(flowEvent),
    .txOut(txOut), .infraredTxOut(infraredTxOut), .rtsN(rtsN), .dtrN(dtrN),
    .eepromClockPin(eepromClockPin), .eepromSelectPin(eepromSelectPin),
    .eepromSerialOutPin(eepromSerialOutPin));
  line_partner u_line (.core_clk(core_clk), .modemSetN(modemSetN), .txOut(txOut),
    .rtsN(rtsN), .dtrN(dtrN), .rxIn(rxIn), .irRxIn(irRxIn), .modemInN(modemInN),
    .lastTx(lastTx));

  // ==========================================================
  // Bus and compare tasks
  // ==========================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic ch, input logic [4:0] idx, input logic [7:0] d);
    @(posedge core_clk);
    regAddr   <= {ch, idx};
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge core_clk);
    regWrStb  <= 1'b0;
  endtask
  task automatic expect_reg(input logic ch, input logic [4:0] idx, input logic [7:0] exp);
    @(posedge core_clk);
    regAddr  <= {ch, idx};
    regRdStb <= 1'b1;
    @(posedge core_clk);
    regRdStb <= 1'b0;
    #1 chk(regRdData, exp, $sformatf("ch%0d reg %h", ch, idx));
  endtask
  task automatic pulse_flow(input logic ch, input logic [3:0] v);
    @(posedge core_clk);
    flowEvent[ch] <= v;
    @(posedge core_clk);
    flowEvent[ch] <= 4'h0;
  endtask
  // Holds reset five cycles and judges the pins while it is held
  task automatic do_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk({6'h00, txOut}, 8'h03, "tx in reset");
    chk({6'h00, lastTx}, 8'h03, "tx seen by line in reset");
    chk({6'h00, infraredTxOut}, 8'h00, "infrared tx in reset");
    chk({4'h0, rtsN, dtrN}, 8'h0F, "modem outputs in reset");
    chk({5'h00, eepromClockPin, eepromSelectPin, eepromSerialOutPin}, 8'h00,
      "eeprom pins in reset");
    @(posedge core_clk);
    rst <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic test_reset_values();
    for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
      for (int i = 0; i < 20; i++) begin
        expect_reg(ch[0], RIDX[i], REXP[i]);
      end
    end
    $display("test reset_values done");
  endtask
  // Dirty ten of the registers, then reset in mid-run
  task automatic test_dirty_reset();
    modemSetN[0] <= 4'hA;
    modemSetN[1] <= 4'h3;
    for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
      for (int i = 0; i < 10; i++) begin
        wr(ch[0], WIDX[i], WVAL[i]);
      end
      expect_reg(ch[0], OFS_DIV_LOW, 8'h5A);
    end
    #1 chk({4'h0, txOut, rtsN}, 8'h00, "break and modem outputs active");
    chk({6'h00, dtrN}, 8'h00, "terminal ready active");
    do_reset();
    test_reset_values();
    // Modem pins held steady across reset, so no change flags
    expect_reg(1'b0, OFS_MODEM_STAT, 8'h50);
    expect_reg(1'b1, OFS_MODEM_STAT, 8'hC0);
    $display("test dirty_reset done");
  endtask
  task automatic test_flow();
    for (int ch = 0; ch < NUM_CHANNELS; ch++) begin
      wr(ch[0], OFS_ENH_FEAT, 8'h0B);
      pulse_flow(ch[0], 4'hF);
      expect_reg(ch[0], OFS_FLOW_STAT, 8'h0F);
      expect_reg(ch[0], OFS_FLOW_STAT, 8'h00);
      pulse_flow(ch[0], 4'h5);
      wr(ch[0], OFS_ENH_FEAT, 8'h00);
      expect_reg(ch[0], OFS_FLOW_STAT, 8'h00);
      wr(ch[0], OFS_ENH_FEAT, 8'h02);
      pulse_flow(ch[0], 4'hA);
    end
    do_reset();
    expect_reg(1'b0, OFS_FLOW_STAT, 8'h00);
    expect_reg(1'b1, OFS_FLOW_STAT, 8'h00);
    $display("test flow done");
  endtask

  // ==========================================================
  // Run control
  // ==========================================================
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    do_reset();
    test_reset_values();
    test_dirty_reset();
    test_flow();
    summarize();
  end
  // Whole sequence is well under a thousand cycles
  initial begin
    #40000;
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    summarize();
  end
endmodule // tb
